/* afdu_pkg.sv */
/*
  Shared constants and types of the audio FIFO DMA unit.
  Assumes one system clock at 40 MHz feeding every part of the unit.
*/
package afdu_pkg;
  localparam int            DW           = 16;
  localparam int            AW           = 9;
  localparam int            FIFO_WORDS   = 384;
  localparam int            SYSTEM_CLOCK_DOMAIN_HZ   = 40000000;
  localparam int            CONV_CLK_HZ  = 1280000;
  localparam int            RATE_MIN_HZ  = 10700;
  localparam int            RATE_MAX_HZ  = 20000;
  // System cycles per converter clock period, rounded down.
  localparam int            CONV_DIV     = SYSTEM_CLOCK_DOMAIN_HZ / CONV_CLK_HZ;
  // Converter clocks per sample at the fastest and slowest rate.
  localparam int            RATE_DIV_MIN = CONV_CLK_HZ / RATE_MAX_HZ;
  localparam int            RATE_DIV_MAX = CONV_CLK_HZ / RATE_MIN_HZ;
  localparam int            DIV_W        = 8;
  localparam int            BUF_DEPTH    = 2;
  localparam logic [AW-1:0] PTR_RST      = 9'h000;
  localparam logic [AW-1:0] PTR_ONE      = 9'h001;
  localparam logic [AW-1:0] PTR_TWO      = 9'h002;

  typedef enum logic [1:0] {
    AFDU_MONO    = 2'h0,
    AFDU_SSTEREO = 2'h1,
    AFDU_MIXED   = 2'h2,
    AFDU_FSTEREO = 2'h3
  } afdu_mode_t;

  typedef enum logic [3:0] {
    OS_IDLE = 4'h1,
    OS_RD0  = 4'h2,
    OS_RD1  = 4'h4,
    OS_LAST = 4'h8
  } afdu_ost_t;
endpackage : afdu_pkg

/* afdu_tick_div.sv */
/*
  Enable-pulse divider: one tick every div enabled cycles.
  Assumes div is at least one and stays stable while counting.
*/
`timescale 1ns/1ps
module afdu_tick_div #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  output wire logic         tick
);
  if (W < 2)
  begin : g_chk
    $error("afdu_tick_div: W too small");
  end

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire  [W-1:0] lastCnt = div - W'(1);

  assign tick     = en & (cnt_reg >= lastCnt);
  assign cnt_next = tick ? '0 : cnt_reg + W'(1);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else if (en)
      cnt_reg <= cnt_next;
  end
endmodule : afdu_tick_div

/* afdu_skid_buf.sv */
/*
  Small FIFO buffer with valid and ready on both sides.
  Assumes DEPTH is a power of two; the drain side may stall at will.
*/
`timescale 1ns/1ps
module afdu_skid_buf #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         inValid,
  output wire logic         inReady,
  input  wire logic [W-1:0] inData,
  output wire logic         outValid,
  input  wire logic         outReady,
  output wire logic [W-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk
    $error("afdu_skid_buf: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0]   count_reg;
  wire           push = inValid & inReady;
  wire           pop  = outValid & outReady;

  assign inReady  = count_reg != (PW+1)'(DEPTH);
  assign outValid = count_reg != '0;
  assign outData  = mem[rdPtr_reg];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_reg] <= inData;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wrPtr_reg <= wrPtr_reg + PW'(push);
      rdPtr_reg <= rdPtr_reg + PW'(pop);
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : afdu_skid_buf

/* afdu_top.sv */
/*
  Audio FIFO DMA unit: moves converter samples into the input FIFO and
  output samples from the output FIFO to the output stage, in shared RAM.
  Assumes one system clock, a shared RAM write port with grant for the
  input FIFO and a read port with one cycle of latency for the output FIFO.
*/
`timescale 1ns/1ps
module afdu_top #(
  parameter int FIFO_LEN = afdu_pkg::FIFO_WORDS
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      cfgEnable,
  input  wire afdu_pkg::afdu_mode_t      cfgMode,
  input  wire logic [afdu_pkg::DIV_W-1:0] cfgRateDiv,
  input  wire logic [afdu_pkg::AW-1:0]   cfgInBase,
  input  wire logic [afdu_pkg::AW-1:0]   cfgOutBase,
  input  wire logic [afdu_pkg::AW-1:0]   cfgLen,
  input  wire logic [afdu_pkg::AW-1:0]   cfgBlock,
  input  wire logic                      lowBattery,
  output wire logic                      sampleTick,
  input  wire logic                      adcValid,
  output wire logic                      adcReady,
  input  wire logic [afdu_pkg::DW-1:0]   adcData0,
  input  wire logic [afdu_pkg::DW-1:0]   adcData1,
  output wire logic                      inWrEn,
  input  wire logic                      inWrGnt,
  output wire logic [afdu_pkg::AW-1:0]   inWrAddr,
  output wire logic [afdu_pkg::DW-1:0]   inWrData,
  output wire logic                      outRdEn,
  output wire logic [afdu_pkg::AW-1:0]   outRdAddr,
  input  wire logic [afdu_pkg::DW-1:0]   outRdData,
  output wire logic                      dacValid,
  output wire logic [afdu_pkg::DW-1:0]   dacData0,
  output wire logic [afdu_pkg::DW-1:0]   dacData1,
  output wire logic                      muted,
  input  wire logic                      blkConsume,
  input  wire logic                      blkProduce,
  output wire logic [afdu_pkg::AW-1:0]   inFill,
  output wire logic [afdu_pkg::AW-1:0]   outFill,
  output wire logic                      blockIrq,
  input  wire logic                      blockAck,
  input  wire logic                      viewReq,
  input  wire logic                      viewOut,
  input  wire logic                      viewSmart,
  input  wire logic [afdu_pkg::AW-1:0]   viewAddr,
  output wire logic                      viewAck,
  output wire logic [afdu_pkg::AW-1:0]   viewPhys
);
  import afdu_pkg::*;

  if (FIFO_LEN < 4 || FIFO_LEN >= (1 << AW))
  begin : g_chk
    $error("afdu_top: FIFO_LEN out of range");
  end

  localparam logic [AW-1:0]    LEN_MAX = AW'(FIFO_LEN);
  localparam logic [DIV_W-1:0] RD_MIN  = DIV_W'(RATE_DIV_MIN);
  localparam logic [DIV_W-1:0] RD_MAX  = DIV_W'(RATE_DIV_MAX);

  function automatic logic [AW-1:0] wrapAdd(input logic [AW-1:0] a,
                                            input logic [AW-1:0] b,
                                            input logic [AW-1:0] lim);
    logic [AW:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, lim})
    begin
      s = s - {1'b0, lim};
    end
    return s[AW-1:0];
  endfunction : wrapAdd

  // Mode decode and limits.
  wire            modeMono = cfgMode == AFDU_MONO;
  wire            modeMix  = cfgMode == AFDU_MIXED;
  wire            modeFull = cfgMode == AFDU_FSTEREO;
  wire            lowerOut = cfgMode == AFDU_SSTEREO || modeMix;
  wire            dualIn   = !modeMono;
  wire [AW-1:0]   lenEff   = (cfgLen > LEN_MAX) ? LEN_MAX : cfgLen;
  wire [AW-1:0]   half     = lenEff >> 1;
  wire [AW-1:0]   outLim   = lowerOut ? half : lenEff;

  // Sample cadence from the converter clock.
  wire             convTick;
  wire [DIV_W-1:0] rateDiv = (cfgRateDiv < RD_MIN) ? RD_MIN :
                             (cfgRateDiv > RD_MAX) ? RD_MAX : cfgRateDiv;

  afdu_tick_div #(
    .W    (DIV_W)
  ) u_convDiv (
    .clk  (clk),
    .nrst (nrst),
    .en   (1'b1),
    .div  (DIV_W'(CONV_DIV)),
    .tick (convTick)
  );

  afdu_tick_div #(
    .W    (DIV_W)
  ) u_rateDiv (
    .clk  (clk),
    .nrst (nrst),
    .en   (convTick & cfgEnable),
    .div  (rateDiv),
    .tick (sampleTick)
  );

  // Input path: buffer, then channel placement.
  wire            bufValid;
  wire            bufPop;
  wire [2*DW-1:0] bufData;

  afdu_skid_buf #(
    .W        (2 * DW),
    .DEPTH    (BUF_DEPTH)
  ) u_buf (
    .clk      (clk),
    .nrst     (nrst),
    .inValid  (adcValid),
    .inReady  (adcReady),
    .inData   ({adcData1, adcData0}),
    .outValid (bufValid),
    .outReady (bufPop),
    .outData  (bufData)
  );

  logic            chSel_reg;
  logic [AW-1:0]   inPtr_reg;
  logic [AW-1:0]   blkCnt_reg;
  logic [AW-1:0]   blkStart_reg;
  logic [AW-1:0]   lastBlk_reg;
  logic [AW-1:0]   inFill_reg;
  logic            blockIrq_reg;

  wire            inWrDo    = inWrEn & inWrGnt;
  wire            lastCh    = !dualIn | chSel_reg;
  wire [AW-1:0]   inOff     = (modeMix & chSel_reg) ? inPtr_reg + half : inPtr_reg;
  wire [AW-1:0]   mixNext   = chSel_reg ? wrapAdd(inPtr_reg, PTR_ONE, half) : inPtr_reg;
  wire [AW-1:0]   inPtr_next = modeMix ? mixNext
                             : wrapAdd(inPtr_reg, PTR_ONE, lenEff);
  wire            blkDone   = inWrDo & (blkCnt_reg == cfgBlock - PTR_ONE);
  wire [AW-1:0]   blkCnt_next = blkDone ? PTR_RST : blkCnt_reg + PTR_ONE;
  wire [AW-1:0]   inFillAdd = inFill_reg + (inWrDo ? PTR_ONE : PTR_RST);
  wire [AW-1:0]   inFill_next = !blkConsume ? inFillAdd
                              : (inFillAdd > cfgBlock) ? inFillAdd - cfgBlock : PTR_RST;

  assign inWrEn   = bufValid & cfgEnable;
  assign bufPop   = inWrDo & lastCh;
  assign inWrData = chSel_reg ? bufData[2*DW-1:DW] : bufData[DW-1:0];
  assign inWrAddr = cfgInBase + inOff;
  assign inFill   = inFill_reg;
  assign blockIrq = blockIrq_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      chSel_reg    <= 1'b0;
      inPtr_reg    <= PTR_RST;
      blkCnt_reg   <= PTR_RST;
      blkStart_reg <= PTR_RST;
      lastBlk_reg  <= PTR_RST;
    end
    else if (!cfgEnable)
    begin
      chSel_reg    <= 1'b0;
      inPtr_reg    <= PTR_RST;
      blkCnt_reg   <= PTR_RST;
      blkStart_reg <= PTR_RST;
      lastBlk_reg  <= PTR_RST;
    end
    else if (inWrDo)
    begin
      chSel_reg  <= dualIn & !chSel_reg;
      inPtr_reg  <= inPtr_next;
      blkCnt_reg <= blkCnt_next;
      if (blkDone)
      begin
        lastBlk_reg  <= blkStart_reg;
        blkStart_reg <= inPtr_next;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      inFill_reg   <= PTR_RST;
      blockIrq_reg <= 1'b0;
    end
    else
    begin
      inFill_reg   <= inFill_next;
      blockIrq_reg <= blkDone | (blockIrq_reg & !blockAck);
    end
  end

  // Coprocessor and core views onto both FIFOs.
  logic [AW-1:0] viewPhys_reg;
  logic          viewAck_reg;
  logic [AW-1:0] outPtr_reg;
  wire  [AW-1:0] viewBase   = viewOut ? cfgOutBase : cfgInBase;
  wire  [AW-1:0] viewAnchor = viewOut ? outPtr_reg : lastBlk_reg;
  wire  [AW-1:0] viewOff    = viewSmart ? wrapAdd(viewAnchor, viewAddr, lenEff)
                                        : wrapAdd(viewAddr, PTR_RST, lenEff);

  assign viewPhys = viewPhys_reg;
  assign viewAck  = viewAck_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      viewPhys_reg <= PTR_RST;
      viewAck_reg  <= 1'b0;
    end
    else
    begin
      viewAck_reg <= viewReq;
      if (viewReq)
        viewPhys_reg <= viewBase + viewOff;
    end
  end

  // Output path.
  afdu_ost_t       state_reg;
  afdu_ost_t       state_next;
  logic            tickPend_reg;
  logic            muted_reg;
  logic            dacValid_reg;
  logic [DW-1:0]   dac0_reg;
  logic [DW-1:0]   dac1_reg;
  logic [AW-1:0]   outFill_reg;

  wire            stIdle   = state_reg == OS_IDLE;
  wire            stRd1    = state_reg == OS_RD1;
  wire            stLast   = state_reg == OS_LAST;
  wire            startRd  = stIdle & tickPend_reg & cfgEnable;
  wire [AW-1:0]   outPtr1  = wrapAdd(outPtr_reg, PTR_ONE, outLim);
  wire [AW-1:0]   outPtr2  = wrapAdd(outPtr1, PTR_ONE, outLim);
  wire [AW-1:0]   outSub   = stLast ? (modeFull ? PTR_TWO : PTR_ONE) : PTR_RST;
  wire [AW-1:0]   outFillAdd = outFill_reg + (blkProduce ? cfgBlock : PTR_RST);
  wire [AW-1:0]   outFill_next = (outFillAdd > outSub) ? outFillAdd - outSub : PTR_RST;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      OS_IDLE: if (startRd) state_next = OS_RD0;
      OS_RD0:  state_next = modeFull ? OS_RD1 : OS_LAST;
      OS_RD1:  state_next = OS_LAST;
      OS_LAST: state_next = OS_IDLE;
    endcase
  end

  assign outRdEn   = (state_reg == OS_RD0) | stRd1;
  assign outRdAddr = cfgOutBase + (stRd1 ? outPtr1 : outPtr_reg);
  assign dacValid  = dacValid_reg;
  assign dacData0  = dac0_reg;
  assign dacData1  = dac1_reg;
  assign muted     = muted_reg;
  assign outFill   = outFill_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= OS_IDLE;
      tickPend_reg <= 1'b0;
      outPtr_reg   <= PTR_RST;
      outFill_reg  <= PTR_RST;
      muted_reg    <= 1'b0;
      dacValid_reg <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      tickPend_reg <= cfgEnable & (sampleTick | (tickPend_reg & !startRd));
      outFill_reg  <= outFill_next;
      muted_reg    <= cfgEnable & (muted_reg | lowBattery);
      dacValid_reg <= stLast;
      if (!cfgEnable)
        outPtr_reg <= PTR_RST;
      else if (stLast)
        outPtr_reg <= modeFull ? outPtr2 : outPtr1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dac0_reg <= '0;
      dac1_reg <= '0;
    end
    else if (stLast && muted_reg)
    begin
      dac0_reg <= '0;
      dac1_reg <= '0;
    end
    else if (stRd1)
      dac0_reg <= outRdData;
    else if (stLast)
    begin
      dac1_reg <= outRdData;
      if (!modeFull)
        dac0_reg <= outRdData;
    end
  end

  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_stereoRead;
    state_reg == OS_RD1 ##1 state_reg == OS_LAST ##1 dacValid;
  endsequence

  a_irq_on_block: assert property (blkDone |=> blockIrq)
    else $error("block interrupt not raised");
  a_irq_held: assert property (blockIrq && !blockAck && !blkDone |=> blockIrq)
    else $error("block interrupt dropped without ack");
  a_wr_in_range: assert property (inWrEn |-> inOff < lenEff)
    else $error("input write outside FIFO length");
  a_mixed_half: assert property (inWrEn && modeMix && chSel_reg |-> inOff >= half)
    else $error("mixed second channel not in upper half");
  a_mono_consec: assert property (inWrDo && modeMono && cfgEnable && $stable(cfgMode)
                   |=> inPtr_reg == wrapAdd($past(inPtr_reg), PTR_ONE, lenEff))
    else $error("mono pointer not consecutive");
  a_stereo_seq: assert property (state_reg == OS_RD0 && modeFull |=> s_stereoRead)
    else $error("full stereo read sequence broken");
  a_tick_served: assert property (sampleTick && stIdle && cfgEnable
                   |-> ##[2:5] dacValid)
    else $error("sample tick not served");
  a_mute_zero: assert property (stLast && muted_reg
                   |=> dacValid && dacData0 == '0 && dacData1 == '0)
    else $error("muted output not silent");
  a_fill_track: assert property (inWrDo && !blkConsume
                   |=> inFill == $past(inFill) + PTR_ONE)
    else $error("input fill not tracked");
  a_buf_hold: assert property (bufValid && !bufPop |=> bufValid && $stable(bufData))
    else $error("buffered sample lost before write");
endmodule : afdu_top

/* afdu_conv_model.sv */
/*
  Converter and shared RAM stand-in: offers sample pairs, grants input
  FIFO writes at random and answers output FIFO reads one cycle later.
  Assumes the unit's converter and RAM ports on the one system clock.
*/
`timescale 1ns/1ps
module afdu_conv_model (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    go,
  input  wire logic                    oneIn,
  input  wire logic                    adcReady,
  input  wire logic                    outRdEn,
  input  wire logic [afdu_pkg::AW-1:0] outRdAddr,
  output logic                         adcValid,
  output logic [afdu_pkg::DW-1:0]      adcData0,
  output logic [afdu_pkg::DW-1:0]      adcData1,
  output logic                         inWrGnt,
  output logic [afdu_pkg::DW-1:0]      outRdData,
  output logic                         idle
);
  import afdu_pkg::*;
  int seed = 98;
  int left;
  assign idle = (left == 0) && !adcValid;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      adcValid  <= 1'h0;
      adcData0  <= 16'h0000;
      adcData1  <= 16'h0000;
      inWrGnt   <= 1'h0;
      outRdData <= 16'h0000;
      left      <= 0;
    end
    else
    begin
      // Grant is withheld often enough that the sample buffer fills.
      inWrGnt   <= ($random(seed) & 7) > 2;
      outRdData <= outRdEn ? {7'h2A, outRdAddr} : ~outRdData;
      if (go)
        left <= 18;
      else if (!adcValid || adcReady)
      begin
        adcValid <= 1'h0;
        adcData0 <= ~adcData0;
        adcData1 <= ~adcData1;
        if (left > 0 && ($random(seed) & 1))
        begin
          adcValid <= 1'h1;
          adcData0 <= 16'($random(seed));
          adcData1 <= oneIn ? 16'h0000 : 16'($random(seed));
          left     <= left - 1;
        end
      end
    end
  end
endmodule : afdu_conv_model

/* afdu_tb.sv */
/*
  Self-checking bench for the audio FIFO DMA unit in all four modes.
  Assumes the converter model file and the unit's package are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import afdu_pkg::*;
  localparam logic [AW-1:0] L   = 9'h008;
  localparam logic [AW-1:0] BLK = 9'h004;
  localparam logic [AW-1:0] IB  = 9'h040;
  localparam logic [AW-1:0] OB  = 9'h100;
  logic             clk, nrst, cfgEnable, lowBattery, adcValid, adcReady, inWrEn;
  logic             inWrGnt, outRdEn, dacValid, muted, blkConsume, blkProduce;
  logic             blockIrq, blockAck, viewReq, viewOut, viewSmart, viewAck;
  logic             sampleTick, go, idle, muteExp;
  afdu_mode_t       cfgMode;
  logic [DIV_W-1:0] cfgRateDiv;
  logic [AW-1:0]    inWrAddr, outRdAddr, inFill, outFill, viewAddr, viewPhys;
  logic [AW-1:0]    ip, op, a0, a1;
  logic [DW-1:0]    adcData0, adcData1, inWrData, outRdData, dacData0, dacData1;
  logic [24:0]      wrQ[$];
  logic [31:0]      dacQ[$];
  int               err_count, n_tests, words, dacSeen, lastTick, cyc, irqSt;
  int               refused, tickExp;

  afdu_top dut (
    .clk, .nrst, .cfgEnable, .cfgMode, .cfgRateDiv, .cfgInBase(IB), .cfgOutBase(OB),
    .cfgLen(L), .cfgBlock(BLK), .lowBattery, .sampleTick, .adcValid, .adcReady,
    .adcData0, .adcData1, .inWrEn, .inWrGnt, .inWrAddr, .inWrData, .outRdEn,
    .outRdAddr, .outRdData, .dacValid, .dacData0, .dacData1, .muted, .blkConsume,
    .blkProduce, .inFill, .outFill, .blockIrq, .blockAck, .viewReq, .viewOut,
    .viewSmart, .viewAddr, .viewAck, .viewPhys
  );
  afdu_conv_model partner (
    .clk, .nrst, .go, .oneIn(cfgMode == AFDU_FSTEREO), .adcReady, .outRdEn,
    .outRdAddr, .adcValid, .adcData0, .adcData1, .inWrGnt, .outRdData, .idle
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Notes expectations as samples are taken and ticks occur.
  always @(posedge clk)
  begin
    cyc++;
    if (adcValid && !adcReady)
      refused++;
    if (adcValid && adcReady && cfgEnable)
    begin
      wrQ.push_back({IB + ip, adcData0});
      if (cfgMode == AFDU_MIXED)
        wrQ.push_back({AW'(IB + ip + L / 2), adcData1});
      else if (cfgMode != AFDU_MONO)
        wrQ.push_back({IB + ip + 9'h001, adcData1});
      ip = (ip + ((cfgMode == AFDU_MONO || cfgMode == AFDU_MIXED) ? 9'h001 : 9'h002))
           % ((cfgMode == AFDU_MIXED) ? L / 2 : L);
    end
    if (sampleTick && cfgEnable)
    begin
      if (lastTick > 0)
        check(cyc - lastTick, tickExp);
      lastTick = cyc;
      a0 = OB + op;
      a1 = (cfgMode == AFDU_FSTEREO) ? a0 + 9'h001 : a0;
      dacQ.push_back(muteExp ? 32'h00000000 : {7'h2A, a0, 7'h2A, a1});
      op = (cfgMode == AFDU_FSTEREO) ? (op + 9'h002) % L
           : (op + 9'h001) % ((cfgMode == AFDU_MONO) ? L : L / 2);
    end
  end

  // Watches the outputs, compares each write and output sample with the oldest note and checks the block interrupt outside mixed mode.
  always @(posedge clk)
  begin
    if (irqSt > 0)
      check(blockIrq, irqSt < 3);
    blockAck <= (irqSt == 1) || (cfgMode == AFDU_MIXED && blockIrq);
    irqSt = (irqSt > 0 && irqSt < 3) ? irqSt + 1 : 0;
    if (inWrEn && inWrGnt)
    begin
      if (wrQ.size() == 0)
        check(1, 0);
      else
        check({inWrAddr, inWrData}, wrQ.pop_front());
      words++;
      if (cfgMode != AFDU_MIXED && words % BLK == 0)
        irqSt = 1;
    end
    if (dacValid)
    begin
      dacSeen++;
      if (dacQ.size() == 0)
        check(1, 0);
      else
        check({dacData0, dacData1}, dacQ.pop_front());
    end
  end

  task automatic start_mode(input afdu_mode_t m, input logic [DIV_W-1:0] d, input int t);
    @(posedge clk);
    cfgMode    <= m;
    cfgRateDiv <= d;
    cfgEnable  <= 1'h1;
    go         <= 1'h1;
    tickExp = t;
    ip = 9'h000;
    op = 9'h000;
    words = 0;
    dacSeen = 0;
    lastTick = 0;
    @(posedge clk) go <= 1'h0;
  endtask : start_mode

  task automatic wait_dac(input int n);
    for (int i = 0; i < 40000 && dacSeen < n; i++)
      @(posedge clk);
    check(dacSeen >= n, 1);
  endtask : wait_dac

  task automatic view_chk(input logic o, input logic s, input logic [AW-1:0] a,
                          input logic [AW-1:0] e);
    @(posedge clk);
    viewReq   <= 1'h1;
    viewOut   <= o;
    viewSmart <= s;
    viewAddr  <= a;
    @(posedge clk) viewReq <= 1'h0;
    @(negedge clk) check({viewAck, viewPhys}, {1'h1, e});
  endtask : view_chk

  task automatic stop_mode(input string name);
    int exp;
    @(negedge clk) check(idle && wrQ.size() == 0, 1);
    check(inFill, words);
    exp = words;
    for (int k = 0; k < 10; k++)
    begin
      @(posedge clk) blkConsume <= 1'h1;
      @(posedge clk) blkConsume <= 1'h0;
      exp = (exp > BLK) ? exp - BLK : 0;
      @(negedge clk) check(inFill, exp);
    end
    @(posedge clk) cfgEnable <= 1'h0;
    muteExp = 1'h0;
    repeat (6) @(posedge clk);
    @(negedge clk) check(muted, 1'h0);
    exp = outFill;
    @(posedge clk) blkProduce <= 1'h1;
    @(posedge clk) blkProduce <= 1'h0;
    @(negedge clk) check(outFill, exp + BLK);
    $display("%s mode done", name);
  endtask : stop_mode

  initial
  begin
    {nrst, cfgEnable, lowBattery, blkConsume, blkProduce, viewReq, go} = 7'h00;
    {viewOut, viewSmart, muteExp} = 3'h0;
    viewAddr = 9'h000;
    cfgMode = AFDU_MONO;
    cfgRateDiv = 8'h40;
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    start_mode(AFDU_MONO, 8'h40, CONV_DIV * RATE_DIV_MIN);
    wait_dac(9);
    view_chk(1'h0, 1'h0, 9'h009, IB + 9'h001);
    view_chk(1'h0, 1'h1, 9'h001, IB + 9'h005);
    view_chk(1'h1, 1'h0, 9'h00A, OB + 9'h002);
    view_chk(1'h1, 1'h1, 9'h002, OB + 9'h003);
    stop_mode("mono");
    start_mode(AFDU_SSTEREO, 8'h0A, CONV_DIV * RATE_DIV_MIN);
    wait_dac(5);
    stop_mode("simple stereo");
    start_mode(AFDU_MIXED, 8'h40, CONV_DIV * RATE_DIV_MIN);
    wait_dac(5);
    stop_mode("mixed");
    start_mode(AFDU_FSTEREO, 8'hC8, CONV_DIV * RATE_DIV_MAX);
    wait_dac(2);
    @(posedge clk) lowBattery <= 1'h1;
    muteExp = 1'h1;
    @(posedge clk) lowBattery <= 1'h0;
    @(negedge clk) check(muted, 1'h1);
    wait_dac(5);
    stop_mode("full stereo");
    check(refused > 0, 1);
    finish_test();
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    finish_test();
  end
endmodule : testbench
